// [design/pcrb_defs.svh]
`ifndef PCRB_DEFS_SVH
`define PCRB_DEFS_SVH

`define PCRB_I2C_ADDR        7'h2d
`define PCRB_OFS_REV         8'h00
`define PCRB_OFS_CONV_EN     8'h01
`define PCRB_OFS_PHASE       8'h02
`define PCRB_OFS_LDO_LVL     8'h10
`define PCRB_OFS_BUCK1_LVL   8'h11
`define PCRB_OFS_BUCK2_LVL   8'h12
`define PCRB_OFS_BUCK3_LVL   8'h13
`define PCRB_OFS_BUCK4_LVL   8'h14
`define PCRB_OFS_BUCK_GRP    8'h15
`define PCRB_OFS_LDO_GRP_EN  8'h16
`define PCRB_OFS_SEQ_GOOD1   8'h17
`define PCRB_OFS_GOOD2       8'h18
`define PCRB_OFS_FAULT_SWITCHING_FREQUENCY_SELECT  8'h19
`define PCRB_OFS_STATUS      8'h1a
`define PCRB_OFS_TEMP        8'h1b
`define PCRB_OFS_AIN1        8'h1c
`define PCRB_OFS_AIN2        8'h1d

`define PCRB_MASK_CONV_EN    8'h01
`define PCRB_MASK_LDO_GRP_EN 8'hdf
`define PCRB_MASK_SEQ_GOOD1  8'hdf
`define PCRB_MASK_GOOD2      8'h1f
`define PCRB_MASK_FAULT_SWITCHING_FREQUENCY_SELECT 8'hef
`define PCRB_BIT_FAULT_CHIP  7

`define PCRB_RST_PHASE       8'h00
`define PCRB_RST_LDO_LVL     8'ha5
`define PCRB_RST_BUCK1_LVL   8'ha5
`define PCRB_RST_BUCK2_LVL   8'h5a
`define PCRB_RST_BUCK3_LVL   8'hd8
`define PCRB_RST_BUCK4_LVL   8'hc0
`define PCRB_RST_BUCK_GRP    8'hf9
`define PCRB_RST_LDO_GRP_EN  8'h1f
`define PCRB_RST_SEQ_GOOD1   8'h44
`define PCRB_RST_GOOD2       8'h1a
`define PCRB_RST_FAULT_SWITCHING_FREQUENCY_SELECT  8'he9
`define PCRB_RST_CONV_EN     8'h00

`define PCRB_ADC_OFFSET      8'h03
`define PCRB_CLK_HZ          50000000
`define PCRB_HOLD_US         2200
`define PCRB_HOLD_CYC        ((`PCRB_CLK_HZ / 1000000) * `PCRB_HOLD_US)
`define PCRB_SLEW_MV_PER_US  10
`define PCRB_RAMP_UV_PER_LSB 6250
`define PCRB_RAMP_STEP_CYC   (((`PCRB_CLK_HZ / 1000000) * `PCRB_RAMP_UV_PER_LSB) / (`PCRB_SLEW_MV_PER_US * 1000))

`endif

// [design/pcrb_pkg.sv]
package pcrb_pkg;
  typedef enum logic [6:0] {
    PCRB_IDLE  = 7'b0000001,
    PCRB_ADDR  = 7'b0000010,
    PCRB_AACK  = 7'b0000100,
    PCRB_WDAT  = 7'b0001000,
    PCRB_WACK  = 7'b0010000,
    PCRB_RDAT  = 7'b0100000,
    PCRB_RACK  = 7'b1000000
  } pcrb_state_t;
endpackage

// [design/pcrb_regbank.sv]
`timescale 1ns/10ps
`include "pcrb_defs.svh"
// Behaviour
// - the bank answers as an i2c slave at seven-bit address 0x2d and lets the host write its runtime registers.
// - an eight-bit converter samples two external inputs and the die temperature sensor in turn.
// - register 0x1b reads the temperature code, 95 plus 1.06 counts per degree above 25 C.
// - registers 0x1c and 0x1d hold the first and second external input results.
// - the external input results carry a nominal offset of plus three codes; the temperature code carries none.
// - a changed buck code ramps its target one step at a time at about 10 V per ms.
// - a rewrite of the same rail level register within 2.2 ms is refused with a nack.
// - the clock line is never held low; refusal is signalled only by nack.
// - bit 7 of 0x19 picks channel-only restart at 0 or whole-chip restart at 1.
module pcrb_regbank #(
  parameter int unsigned HOLD_CYC      = `PCRB_HOLD_CYC,
  parameter int unsigned RAMP_STEP_CYC = `PCRB_RAMP_STEP_CYC
) (
  input  wire logic       SYS_CLK_IN,
  input  wire logic       NRST_IN,
  input  wire logic       CLK_EN_IN,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE_OUT,
  input  wire logic [7:0] REVISION_IN,
  input  wire logic [7:0] STATUS_FLAGS_IN,
  input  wire logic [7:0] TEMP_SAMPLE_IN,
  input  wire logic [7:0] AIN_FIRST_SAMPLE_IN,
  input  wire logic [7:0] AIN_SECOND_SAMPLE_IN,
  output logic [1:0]      CONV_CHANNEL_OUT,
  output logic [7:0]      PHASE_INTERLEAVE_OUT,
  output logic [7:0]      LINEAR_RAIL_VOLTAGE_CODE_OUT,
  output logic [7:0]      FIRST_BUCK_VOLTAGE_CODE_OUT,
  output logic [7:0]      SECOND_BUCK_VOLTAGE_CODE_OUT,
  output logic [7:0]      THIRD_BUCK_VOLTAGE_CODE_OUT,
  output logic [7:0]      FOURTH_BUCK_VOLTAGE_CODE_OUT,
  output logic [7:0]      BUCK_GROUP_OUT,
  output logic [7:0]      LDO_GROUP_ENABLE_OUT,
  output logic [7:0]      SEQ_GOOD_ONE_OUT,
  output logic [7:0]      GOOD_TWO_OUT,
  output logic            CHIP_FAULT_ACTION_OUT,
  output logic [6:0]      FAULT_DOWNSEQ_SWITCHING_FREQUENCY_SELECT_OUT
);
  if (HOLD_CYC < 1 || RAMP_STEP_CYC < 1) begin : g_bad_counts
    $error("counts must be at least one");
  end

  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[8] ? 8'hff : s[7:0];
  endfunction

  // pin synchronisers
  logic [1:0] scl_sync_r, sda_sync_r;
  logic       scl_d_r, sda_d_r;
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else if (CLK_EN_IN) begin
      scl_sync_r <= {scl_sync_r[0], SCL_IN};
      sda_sync_r <= {sda_sync_r[0], SDA_IN};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end
  wire scl_s   = scl_sync_r[1];
  wire sda_s   = sda_sync_r[1];
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire i2c_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire i2c_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // register storage
  logic [7:0] reg_r [0:11];
  logic [7:0] reg_nxt [0:11];
  logic [7:0] temp_r, ain1_r, ain2_r, temp_nxt, ain1_nxt, ain2_nxt;
  logic [1:0] chan_r, chan_nxt;
  logic [31:0] hold_cnt_r [0:4];
  logic [31:0] hold_cnt_nxt [0:4];
  logic [7:0] ramp_r [0:3];
  logic [7:0] ramp_nxt [0:3];
  logic [31:0] ramp_cnt_r, ramp_cnt_nxt;
  localparam logic [7:0] reg_rst_val [0:11] = '{`PCRB_RST_CONV_EN, `PCRB_RST_PHASE,
    `PCRB_RST_LDO_LVL, `PCRB_RST_BUCK1_LVL, `PCRB_RST_BUCK2_LVL, `PCRB_RST_BUCK3_LVL,
    `PCRB_RST_BUCK4_LVL, `PCRB_RST_BUCK_GRP, `PCRB_RST_LDO_GRP_EN, `PCRB_RST_SEQ_GOOD1,
    `PCRB_RST_GOOD2, `PCRB_RST_FAULT_SWITCHING_FREQUENCY_SELECT};

  // i2c engine state
  pcrb_pkg::pcrb_state_t st_r, st_nxt;
  logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, rd_byte;
  logic [3:0] bit_r, bit_nxt;
  logic       rw_r, rw_nxt, first_r, first_nxt, nack_r, nack_nxt;
  logic       oe_r, oe_nxt;

  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    case (a)
      `PCRB_OFS_REV:    rd_mux = REVISION_IN;
      `PCRB_OFS_STATUS: rd_mux = STATUS_FLAGS_IN;
      `PCRB_OFS_TEMP:   rd_mux = temp_r;
      `PCRB_OFS_AIN1:   rd_mux = ain1_r;
      `PCRB_OFS_AIN2:   rd_mux = ain2_r;
      default:          rd_mux = (wr_idx(a) == 4'hf) ? 8'h00 : reg_r[wr_idx(a)];
    endcase
  endfunction

  // index into writable store, 4'hf for none
  function automatic logic [3:0] wr_idx(input logic [7:0] a);
    case (a)
      `PCRB_OFS_CONV_EN:    wr_idx = 4'h0;
      `PCRB_OFS_PHASE:      wr_idx = 4'h1;
      `PCRB_OFS_LDO_LVL:    wr_idx = 4'h2;
      `PCRB_OFS_BUCK1_LVL:  wr_idx = 4'h3;
      `PCRB_OFS_BUCK2_LVL:  wr_idx = 4'h4;
      `PCRB_OFS_BUCK3_LVL:  wr_idx = 4'h5;
      `PCRB_OFS_BUCK4_LVL:  wr_idx = 4'h6;
      `PCRB_OFS_BUCK_GRP:   wr_idx = 4'h7;
      `PCRB_OFS_LDO_GRP_EN: wr_idx = 4'h8;
      `PCRB_OFS_SEQ_GOOD1:  wr_idx = 4'h9;
      `PCRB_OFS_GOOD2:      wr_idx = 4'ha;
      `PCRB_OFS_FAULT_SWITCHING_FREQUENCY_SELECT: wr_idx = 4'hb;
      default:              wr_idx = 4'hf;
    endcase
  endfunction

  function automatic logic [7:0] wr_mask(input logic [3:0] i);
    case (i)
      4'h0:    wr_mask = `PCRB_MASK_CONV_EN;
      4'h8:    wr_mask = `PCRB_MASK_LDO_GRP_EN;
      4'h9:    wr_mask = `PCRB_MASK_SEQ_GOOD1;
      4'ha:    wr_mask = `PCRB_MASK_GOOD2;
      4'hb:    wr_mask = `PCRB_MASK_FAULT_SWITCHING_FREQUENCY_SELECT;
      default: wr_mask = 8'hff;
    endcase
  endfunction

  wire [3:0] cur_idx  = wr_idx(ptr_r);
  wire       is_level = (cur_idx >= 4'h2) && (cur_idx <= 4'h6);
  wire [2:0] lvl      = 3'(cur_idx - 4'h2);

  always_comb begin
    st_nxt    = st_r;
    sh_nxt    = sh_r;
    ptr_nxt   = ptr_r;
    bit_nxt   = bit_r;
    rw_nxt    = rw_r;
    first_nxt = first_r;
    nack_nxt  = nack_r;
    oe_nxt    = oe_r;
    rd_byte   = rd_mux(ptr_r);
    for (int i = 0; i < 12; i++) reg_nxt[i] = reg_r[i];
    for (int i = 0; i < 5; i++) hold_cnt_nxt[i] = (hold_cnt_r[i] != 32'd0) ? hold_cnt_r[i] - 32'd1 : 32'd0;
    // never drive scl; only sda for ack or data
    if (i2c_start) begin
      st_nxt  = pcrb_pkg::PCRB_ADDR;
      bit_nxt = 4'h0;
      oe_nxt  = 1'b0;
    end else if (i2c_stop) begin
      st_nxt = pcrb_pkg::PCRB_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        pcrb_pkg::PCRB_IDLE: begin
          oe_nxt = 1'b0;
        end
        pcrb_pkg::PCRB_ADDR, pcrb_pkg::PCRB_WDAT: begin
          if (scl_rise) begin
            sh_nxt  = {sh_r[6:0], sda_s};
            bit_nxt = bit_r + 4'h1;
          end
          if (scl_fall && bit_r == 4'h8) begin
            bit_nxt = 4'h0;
            if (st_r == pcrb_pkg::PCRB_ADDR) begin
              if (sh_r[7:1] == `PCRB_I2C_ADDR) begin
                rw_nxt    = sh_r[0];
                first_nxt = 1'b1;
                oe_nxt    = 1'b1;
                st_nxt    = pcrb_pkg::PCRB_AACK;
              end else begin
                st_nxt = pcrb_pkg::PCRB_IDLE;
              end
            end else begin
              nack_nxt = 1'b0;
              if (first_r) begin
                ptr_nxt   = sh_r;
                first_nxt = 1'b0;
              end else if (cur_idx != 4'hf) begin
                if (is_level && hold_cnt_r[lvl] != 32'd0) begin
                  nack_nxt = 1'b1;
                end else begin
                  reg_nxt[cur_idx] = sh_r & wr_mask(cur_idx);
                  if (is_level) hold_cnt_nxt[lvl] = HOLD_CYC;
                end
                ptr_nxt = ptr_r + 8'h01;
              end else begin
                ptr_nxt = ptr_r + 8'h01;
              end
              oe_nxt = ~nack_nxt;
              st_nxt = pcrb_pkg::PCRB_WACK;
            end
          end
        end
        pcrb_pkg::PCRB_AACK, pcrb_pkg::PCRB_WACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              sh_nxt    = rd_byte;
              ptr_nxt   = ptr_r + 8'h01;
              oe_nxt    = ~rd_byte[7];
              bit_nxt   = 4'h1;
              st_nxt    = pcrb_pkg::PCRB_RDAT;
            end else begin
              oe_nxt = 1'b0;
              st_nxt = pcrb_pkg::PCRB_WDAT;
            end
          end
        end
        pcrb_pkg::PCRB_RDAT: begin
          if (scl_fall) begin
            if (bit_r == 4'h8) begin
              oe_nxt = 1'b0;
              st_nxt = pcrb_pkg::PCRB_RACK;
            end else begin
              oe_nxt  = ~sh_r[3'(7 - bit_r)];
              bit_nxt = bit_r + 4'h1;
            end
          end
        end
        pcrb_pkg::PCRB_RACK: begin
          if (scl_rise) nack_nxt = sda_s;
          if (scl_fall) begin
            if (nack_r) begin
              st_nxt = pcrb_pkg::PCRB_IDLE;
            end else begin
              sh_nxt  = rd_byte;
              ptr_nxt = ptr_r + 8'h01;
              oe_nxt  = ~rd_byte[7];
              bit_nxt = 4'h1;
              st_nxt  = pcrb_pkg::PCRB_RDAT;
            end
          end
        end
        default: st_nxt = pcrb_pkg::PCRB_IDLE;
      endcase
    end
  end

  // converter: rotate channels when enabled, offset applied to external inputs only
  always_comb begin
    chan_nxt = chan_r;
    temp_nxt = temp_r;
    ain1_nxt = ain1_r;
    ain2_nxt = ain2_r;
    if (reg_r[0][0]) begin
      case (chan_r)
        2'h0: ain1_nxt = sat_add(AIN_FIRST_SAMPLE_IN, `PCRB_ADC_OFFSET);
        2'h1: ain2_nxt = sat_add(AIN_SECOND_SAMPLE_IN, `PCRB_ADC_OFFSET);
        default: temp_nxt = TEMP_SAMPLE_IN;
      endcase
      chan_nxt = (chan_r == 2'h2) ? 2'h0 : chan_r + 2'h1;
    end
  end

  // buck code ramp, one lsb per step
  always_comb begin
    ramp_cnt_nxt = (ramp_cnt_r == 32'd0) ? RAMP_STEP_CYC - 32'd1 : ramp_cnt_r - 32'd1;
    for (int i = 0; i < 4; i++) begin
      ramp_nxt[i] = ramp_r[i];
      if (ramp_cnt_r == 32'd0) begin
        if (ramp_r[i] < reg_r[3 + i]) ramp_nxt[i] = ramp_r[i] + 8'h01;
        else if (ramp_r[i] > reg_r[3 + i]) ramp_nxt[i] = ramp_r[i] - 8'h01;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      st_r <= pcrb_pkg::PCRB_IDLE;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      bit_r <= 4'h0;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      nack_r <= 1'b0;
      oe_r <= 1'b0;
      for (int i = 0; i < 12; i++) reg_r[i] <= reg_rst_val[i];
      for (int i = 0; i < 4; i++) ramp_r[i] <= reg_rst_val[3 + i];
      ramp_cnt_r <= 32'd0;
      for (int i = 0; i < 5; i++) hold_cnt_r[i] <= 32'd0;
      temp_r <= 8'h00;
      ain1_r <= 8'h00;
      ain2_r <= 8'h00;
      chan_r <= 2'h0;
    end else if (CLK_EN_IN) begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      bit_r <= bit_nxt;
      rw_r <= rw_nxt;
      first_r <= first_nxt;
      nack_r <= nack_nxt;
      oe_r <= oe_nxt;
      for (int i = 0; i < 12; i++) reg_r[i] <= reg_nxt[i];
      for (int i = 0; i < 4; i++) ramp_r[i] <= ramp_nxt[i];
      ramp_cnt_r <= ramp_cnt_nxt;
      for (int i = 0; i < 5; i++) hold_cnt_r[i] <= hold_cnt_nxt[i];
      temp_r <= temp_nxt;
      ain1_r <= ain1_nxt;
      ain2_r <= ain2_nxt;
      chan_r <= chan_nxt;
    end
  end

  // open drain: only ever pulls low
  assign SDA_OUT = 1'b0;
  assign SDA_OE_OUT = oe_r;
  assign CONV_CHANNEL_OUT = chan_r;
  assign PHASE_INTERLEAVE_OUT = reg_r[1];
  assign LINEAR_RAIL_VOLTAGE_CODE_OUT = reg_r[2];
  assign FIRST_BUCK_VOLTAGE_CODE_OUT = ramp_r[0];
  assign SECOND_BUCK_VOLTAGE_CODE_OUT = ramp_r[1];
  assign THIRD_BUCK_VOLTAGE_CODE_OUT = ramp_r[2];
  assign FOURTH_BUCK_VOLTAGE_CODE_OUT = ramp_r[3];
  assign BUCK_GROUP_OUT = reg_r[7];
  assign LDO_GROUP_ENABLE_OUT = reg_r[8];
  assign SEQ_GOOD_ONE_OUT = reg_r[9];
  assign GOOD_TWO_OUT = reg_r[10];
  assign CHIP_FAULT_ACTION_OUT = reg_r[11][`PCRB_BIT_FAULT_CHIP];
  assign FAULT_DOWNSEQ_SWITCHING_FREQUENCY_SELECT_OUT = reg_r[11][6:0];
endmodule

// [sim/pcrb_props.sv]
`timescale 1ns/10ps
module pcrb_props #(
  parameter int unsigned HOLD_CYC      = 20,
  parameter int unsigned RAMP_STEP_CYC = 2
) (
  input wire logic       SYS_CLK_IN,
  input wire logic       NRST_IN,
  input wire logic       CLK_EN_IN,
  input wire logic       SCL_IN,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE_OUT,
  input wire logic [1:0] CONV_CHANNEL_OUT,
  input wire logic [7:0] THIRD_BUCK_VOLTAGE_CODE_OUT,
  input wire logic [7:0] LDO_GROUP_ENABLE_OUT,
  input wire logic [7:0] GOOD_TWO_OUT,
  input wire logic [6:0] FAULT_DOWNSEQ_SWITCHING_FREQUENCY_SELECT_OUT
);
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!NRST_IN);
  sequence s_moved;
    $changed(THIRD_BUCK_VOLTAGE_CODE_OUT);
  endsequence
  sequence s_one_code;
    (THIRD_BUCK_VOLTAGE_CODE_OUT - $past(THIRD_BUCK_VOLTAGE_CODE_OUT)) inside {8'h01, 8'hff};
  endsequence
  property p_ramp_unit;
    s_moved |-> s_one_code;
  endproperty
  a_ramp_unit: assert property (p_ramp_unit) else $error("buck code jumped");
  property p_ramp_dwell;
    s_moved |=> $stable(THIRD_BUCK_VOLTAGE_CODE_OUT);
  endproperty
  a_ramp_dwell: assert property (p_ramp_dwell) else $error("buck ramp too fast");
  property p_chan_rot;
    $changed(CONV_CHANNEL_OUT) |-> $past(CLK_EN_IN) &&
      CONV_CHANNEL_OUT == (($past(CONV_CHANNEL_OUT) == 2'h2) ? 2'h0 : $past(CONV_CHANNEL_OUT) + 2'h1);
  endproperty
  a_chan_rot: assert property (p_chan_rot) else $error("channel order wrong");
  property p_freeze;
    !CLK_EN_IN |=> $stable(CONV_CHANNEL_OUT) && $stable(SDA_OE_OUT);
  endproperty
  a_freeze: assert property (p_freeze) else $error("moved while gated");
  property p_oe_scl_low;
    $changed(SDA_OE_OUT) |-> !SCL_IN;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda moved with scl high");
  property p_oe_hold;
    $rose(SCL_IN) |=> $stable(SDA_OE_OUT)[*4];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("sda not held");
  property p_sda_low;
    SDA_OE_OUT |-> !SDA_OUT;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda driven high");
  property p_mask;
    !LDO_GROUP_ENABLE_OUT[5] && GOOD_TWO_OUT[7:5] == 3'h0 && !FAULT_DOWNSEQ_SWITCHING_FREQUENCY_SELECT_OUT[4];
  endproperty
  a_mask: assert property (p_mask) else $error("unassigned bit set");
endmodule
bind pcrb_regbank pcrb_props #(
  .HOLD_CYC(HOLD_CYC), .RAMP_STEP_CYC(RAMP_STEP_CYC)
) i_pcrb_props (
  .SYS_CLK_IN(SYS_CLK_IN), .NRST_IN(NRST_IN), .CLK_EN_IN(CLK_EN_IN), .SCL_IN(SCL_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .CONV_CHANNEL_OUT(CONV_CHANNEL_OUT),
  .THIRD_BUCK_VOLTAGE_CODE_OUT(THIRD_BUCK_VOLTAGE_CODE_OUT),
  .LDO_GROUP_ENABLE_OUT(LDO_GROUP_ENABLE_OUT), .GOOD_TWO_OUT(GOOD_TWO_OUT),
  .FAULT_DOWNSEQ_SWITCHING_FREQUENCY_SELECT_OUT(FAULT_DOWNSEQ_SWITCHING_FREQUENCY_SELECT_OUT));

// [sim/pcrb_host.sv]
`timescale 1ns/10ps
`include "pcrb_defs.svh"
module pcrb_host (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // ten-cycle scl phases, never stretched
  task automatic bit_x(input logic b, output logic r);
    sda_oe_out <= ~b;
    w(5);
    scl_out <= 1'b1;
    w(5);
    r = sda_in;
    w(5);
    scl_out <= 1'b0;
    w(5);
  endtask
  task automatic start();
    sda_oe_out <= 1'b0;
    scl_out <= 1'b1;
    w(10);
    sda_oe_out <= 1'b1;
    w(10);
    scl_out <= 1'b0;
    w(5);
  endtask
  task automatic stop();
    sda_oe_out <= 1'b1;
    w(5);
    scl_out <= 1'b1;
    w(10);
    sda_oe_out <= 1'b0;
    w(10);
  endtask
  task automatic xfer(input logic [7:0] v, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(v[i], r);
      q[i] = r;
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  // caller spaces level rewrites and static settings
  task automatic wr(input logic [7:0] p, input logic [7:0] v, output logic ack);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    start();
    xfer({`PCRB_I2C_ADDR, 1'b0}, q, a0);
    xfer(p, q, a1);
    xfer(v, q, ack);
    stop();
    ack = ack & a0 & a1;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
                    output logic ack);
    logic [7:0] q;
    logic       a1;
    start();
    xfer({a, 1'b0}, q, ack);
    xfer(p, q, a1);
    stop();
    start();
    xfer({a, 1'b1}, q, a1);
    xfer(8'hff, d, a1);
    stop();
  endtask
endmodule

// [sim/tb.sv]
`timescale 1ns/10ps
`include "pcrb_defs.svh"
module tb;
  localparam int unsigned HOLD   = 2000;
  localparam logic [7:0]  REV_ID = 8'h3c; // arbitrary value
  logic       clk, rst_n, clk_en, scl, h_oe, sda, sda_o, sda_oe, fca, ack;
  logic [7:0] stat, temp, ain1, ain2, ph, ldo, b1, b2, b3, b4, bg, lg, sg1, g2, d;
  logic [1:0] chan;
  logic [6:0] ffq;
  int         errors, cmp_count;
  assign sda = ~(h_oe | (sda_oe & ~sda_o));
  pcrb_regbank #(.HOLD_CYC(HOLD), .RAMP_STEP_CYC(2)) i_pcrb_regbank (
    .SYS_CLK_IN(clk), .NRST_IN(rst_n), .CLK_EN_IN(clk_en), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .REVISION_IN(REV_ID),
    .STATUS_FLAGS_IN(stat), .TEMP_SAMPLE_IN(temp), .AIN_FIRST_SAMPLE_IN(ain1),
    .AIN_SECOND_SAMPLE_IN(ain2), .CONV_CHANNEL_OUT(chan), .PHASE_INTERLEAVE_OUT(ph),
    .LINEAR_RAIL_VOLTAGE_CODE_OUT(ldo), .FIRST_BUCK_VOLTAGE_CODE_OUT(b1),
    .SECOND_BUCK_VOLTAGE_CODE_OUT(b2), .THIRD_BUCK_VOLTAGE_CODE_OUT(b3),
    .FOURTH_BUCK_VOLTAGE_CODE_OUT(b4), .BUCK_GROUP_OUT(bg), .LDO_GROUP_ENABLE_OUT(lg),
    .SEQ_GOOD_ONE_OUT(sg1), .GOOD_TWO_OUT(g2), .CHIP_FAULT_ACTION_OUT(fca),
    .FAULT_DOWNSEQ_SWITCHING_FREQUENCY_SELECT_OUT(ffq));
  pcrb_host i_pcrb_host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_oe_out(h_oe));
  task automatic end_sim();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v, input logic ea);
    i_pcrb_host.wr(p, v, ack);
    chk("write ack", {7'h00, ea}, {7'h00, ack});
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    i_pcrb_host.rd(`PCRB_I2C_ADDR, p, d, ack);
    chk("read ack", 8'h01, {7'h00, ack});
    chk($sformatf("reg %h", p), e, d);
  endtask
  task automatic t_reset();
    logic [7:0] ev[10] = '{8'ha5, 8'ha5, 8'h5a, 8'hd8, 8'hc0, 8'hf9, 8'h1f, 8'h44, 8'h1a, 8'he9};
    for (int i = 0; i < 10; i++) begin
      rd(8'h10 + 8'(i), ev[i]);
    end
    rd(8'h02, 8'h00);
    chk("phase out", `PCRB_RST_PHASE, ph);
    chk("buck one out", `PCRB_RST_BUCK1_LVL, b1);
    chk("buck two out", `PCRB_RST_BUCK2_LVL, b2);
    chk("buck four out", `PCRB_RST_BUCK4_LVL, b4);
    chk("buck group out", `PCRB_RST_BUCK_GRP, bg);
    chk("seq good out", `PCRB_RST_SEQ_GOOD1, sg1);
  endtask
  task automatic t_addr();
    i_pcrb_host.rd(7'h2c, 8'h00, d, ack);
    chk("foreign address ack", 8'h00, {7'h00, ack});
    wr(8'h00, 8'h00, 1'b1);
    wr(8'h1a, 8'h00, 1'b1);
    rd(8'h00, REV_ID);
    rd(8'h1a, stat);
  endtask
  task automatic t_mask();
    logic [7:0] ofs[4] = '{8'h01, 8'h16, 8'h17, 8'h18};
    logic [7:0] ev[4] = '{8'h01, 8'hdf, 8'hdf, 8'h1f};
    for (int i = 0; i < 4; i++) begin
      wr(ofs[i], 8'hff, 1'b1);
      rd(ofs[i], ev[i]);
    end
    chk("group enable out", `PCRB_MASK_LDO_GRP_EN, lg);
    chk("seq good masked out", `PCRB_MASK_SEQ_GOOD1, sg1);
    chk("good two out", `PCRB_MASK_GOOD2, g2);
  endtask
  task automatic t_fault();
    logic [7:0] v[2] = '{8'h75, 8'h8a};
    for (int i = 0; i < 2; i++) begin
      wr(8'h19, v[i], 1'b1);
      chk("fault action", {7'h00, v[i][7]}, {7'h00, fca});
      chk("fault switching_frequency_select", {1'b0, v[i][6:0]} & `PCRB_MASK_FAULT_SWITCHING_FREQUENCY_SELECT, {1'b0, ffq});
      rd(8'h19, v[i] & `PCRB_MASK_FAULT_SWITCHING_FREQUENCY_SELECT);
    end
  endtask
  task automatic t_conv();
    temp <= 8'h5f;
    ain1 <= 8'h10;
    ain2 <= 8'hfe;
    repeat (10) @(posedge clk);
    rd(8'h1b, 8'h5f);
    rd(8'h1c, 8'h13);
    rd(8'h1d, 8'hff);
    ain1 <= 8'h00;
    repeat (10) @(posedge clk);
    rd(8'h1c, 8'h03);
  endtask
  task automatic t_freeze();
    logic [1:0] c;
    clk_en <= 1'b0;
    repeat (2) @(posedge clk);
    c = chan;
    repeat (4) @(posedge clk);
    chk("gated channel", {6'h00, c}, {6'h00, chan});
    clk_en <= 1'b1;
  endtask
  task automatic t_ramp();
    wr(8'h13, 8'h40, 1'b1);
    chk("ramp in progress", 8'h01, {7'h00, b3 !== 8'h40});
    wr(8'h10, 8'h80, 1'b1);
    chk("linear code", 8'h80, ldo);
    wr(8'h13, 8'h41, 1'b0);
    for (int i = 0; i < 1000 && b3 !== 8'h40; i++)
      @(posedge clk);
    chk("ramp end", 8'h40, b3);
    if (b3 !== 8'h40) end_sim();
    rd(8'h13, 8'h40);
    repeat (HOLD) @(posedge clk);
    wr(8'h13, 8'h41, 1'b1);
    rd(8'h13, 8'h41);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    stat = 8'h5a;
    temp = 8'h00;
    ain1 = 8'h00;
    ain2 = 8'h00;
    errors = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_addr();
    t_mask();
    t_fault();
    t_conv();
    t_freeze();
    t_ramp();
    end_sim();
  end
endmodule
